/* shared/ddrc_defs.vh */
// Constants for the DDR command decode and power state block
`ifndef DDRC_DEFS_VH
`define DDRC_DEFS_VH
// Command codes on {ras_n, cas_n, we_n} with chip select low
`define DDRC_CMD_NOP    3'h7
`define DDRC_CMD_ACT    3'h3
`define DDRC_CMD_READ   3'h5
`define DDRC_CMD_WRITE  3'h4
`define DDRC_CMD_BST    3'h6
`define DDRC_CMD_PRE    3'h2
`define DDRC_CMD_REF    3'h1
`define DDRC_CMD_MRS    3'h0
// Decoded command kinds reported on cmd_kind_ff
`define DDRC_K_NONE     4'h0
`define DDRC_K_ACT      4'h1
`define DDRC_K_READ     4'h2
`define DDRC_K_WRITE    4'h3
`define DDRC_K_BST      4'h4
`define DDRC_K_PRE      4'h5
`define DDRC_K_PREALL   4'h6
`define DDRC_K_AREF     4'h7
`define DDRC_K_SREF     4'h8
`define DDRC_K_MRS      4'h9
`define DDRC_K_EMRS     4'ha
// Power states
`define DDRC_PS_NORMAL  2'h0
`define DDRC_PS_PPD     2'h1
`define DDRC_PS_APD     2'h2
`define DDRC_PS_SREF    2'h3
// Mode register bank selects
`define DDRC_BA_MODE    2'h0
`define DDRC_BA_EMODE   2'h1
// Auto-precharge bit positions per width
`define DDRC_AP_BIT_X32 8
`define DDRC_AP_BIT_X8  10
// Base mode register fields
`define DDRC_MR_BL_LSB  0
`define DDRC_MR_BT_BIT  3
`define DDRC_MR_CL_LSB  4
`define DDRC_MR_DLL_BIT 8
`endif

/* hw/ddrc_cmd.v */
// DDR SDRAM command decode, power state and mode register capture
//
// Summary of operation
// - Sample commands on rising differential clock
// - Deselect and NOP behave identically
// - ACTIVE opens row in chosen bank
// - Read or write burst at column
// - Auto-precharge applies per command only
// - Burst terminate only for plain reads
// - Precharge one bank or all banks
// - Auto refresh, or self refresh when cke low
// - Refresh uses internal counters, ignores address
// - Mode register set loads opcode
// - Data mask high blocks element write
// - Auto-precharge bit position depends on width
// - Cke falling enters precharge or active power-down
// - Cke low holds power state
// - Mode registers reset to zero and not valid
// - Core word is two pin transfers
// - Bank address selects base or extended register
// - Base register holds length, type, latency, loop reset
`timescale 1ns/1ps
`include "ddrc_defs.vh"

module ddrc_cmd #(
  parameter DQ_W  = 16,
  parameter AP_BIT = `DDRC_AP_BIT_X8,
  parameter ROW_W = 13
) (
  input  wire              mclk,
  input  wire              rst,
  input  wire              ck_p,
  input  wire              ck_n,
  input  wire              cke,
  input  wire              cs_n,
  input  wire              ras_n,
  input  wire              cas_n,
  input  wire              we_n,
  input  wire [1:0]        ba,
  input  wire [ROW_W-1:0]  addr,
  input  wire [DQ_W-1:0]   dq_in,
  input  wire              dm,
  output reg  [3:0]        cmd_kind_ff,
  output reg               cmd_stb_ff,
  output reg  [1:0]        cmd_bank_ff,
  output reg  [ROW_W-1:0]  cmd_addr_ff,
  output reg               cmd_ap_ff,
  output reg  [3:0]        bank_open_ff,
  output reg  [1:0]        pwr_state_ff,
  output reg  [ROW_W-1:0]  mode_reg_ff,
  output reg  [ROW_W-1:0]  emode_reg_ff,
  output reg               mode_valid_ff,
  output reg               emode_valid_ff,
  output reg               dll_reset_ff,
  output reg  [2:0]        burst_len_ff,
  output reg               burst_type_ff,
  output reg  [2:0]        cas_lat_ff,
  output reg  [1:0]        ref_bank_ff,
  output reg  [ROW_W-1:0]  ref_row_ff,
  output reg               rd_active_ff,
  output reg  [2*DQ_W-1:0] wr_word_ff,
  output reg  [1:0]        wr_mask_ff,
  output reg               wr_word_stb_ff
);

  ////////////////////////////////////////////////////////////////////////
  // Two flop synchronisers for all pins
  localparam IN_W = 2 + 5 + 2 + ROW_W + DQ_W + 1;
  reg  [IN_W-1:0] meta_ff;
  reg  [IN_W-1:0] sync_ff;
  wire [IN_W-1:0] pins = {ck_p, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in, dm};

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= {IN_W{1'b0}};
      sync_ff <= {IN_W{1'b0}};
    end else begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
    end
  end

  wire              s_ckp  = sync_ff[IN_W-1];
  wire              s_ckn  = sync_ff[IN_W-2];
  wire              s_cke  = sync_ff[IN_W-3];
  wire              s_cs_n = sync_ff[IN_W-4];
  wire [2:0]        s_rcw  = sync_ff[IN_W-5 -: 3];
  wire [1:0]        s_ba   = sync_ff[IN_W-8 -: 2];
  wire [ROW_W-1:0]  s_addr = sync_ff[DQ_W+ROW_W:DQ_W+1];
  wire [DQ_W-1:0]   s_dq   = sync_ff[DQ_W:1];
  wire              s_dm   = sync_ff[0];

  ////////////////////////////////////////////////////////////////////////
  // Crossing detect on the differential pair
  reg ckx_ff;
  reg cke_prev_ff;
  wire ckx  = s_ckp & ~s_ckn;
  wire rise = ckx & ~ckx_ff;
  wire fall = ~ckx & ckx_ff;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ckx_ff      <= 1'b0;
      cke_prev_ff <= 1'b0;
    end else begin
      ckx_ff <= ckx;
      if (rise) begin
        cke_prev_ff <= s_cke;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  function [3:0] decode;
    input       csn;
    input [2:0] rcw;
    input       ap;
    input [1:0] b;
    input       ck_en;
    begin
      decode = `DDRC_K_NONE;
      if (!csn) begin
        case (rcw)
          `DDRC_CMD_ACT:   decode = `DDRC_K_ACT;
          `DDRC_CMD_READ:  decode = `DDRC_K_READ;
          `DDRC_CMD_WRITE: decode = `DDRC_K_WRITE;
          `DDRC_CMD_BST:   decode = `DDRC_K_BST;
          `DDRC_CMD_PRE:   decode = ap ? `DDRC_K_PREALL : `DDRC_K_PRE;
          `DDRC_CMD_REF:   decode = ck_en ? `DDRC_K_AREF : `DDRC_K_SREF;
          `DDRC_CMD_MRS: begin
            if (b == `DDRC_BA_MODE) begin
              decode = `DDRC_K_MRS;
            end else if (b == `DDRC_BA_EMODE) begin
              decode = `DDRC_K_EMRS;
            end else begin
              decode = `DDRC_K_NONE;
            end
          end
          default:         decode = `DDRC_K_NONE;
        endcase
      end
    end
  endfunction

  wire       s_ap    = s_addr[AP_BIT];
  wire [3:0] kind    = decode(s_cs_n, s_rcw, s_ap, s_ba, s_cke);
  wire       in_norm = (pwr_state_ff == `DDRC_PS_NORMAL);
  // Clock enable must be high on both crossings, except for self refresh entry
  wire       exec    = rise & in_norm & cke_prev_ff & (s_cke | (kind == `DDRC_K_SREF));
  wire       idle    = (bank_open_ff == 4'h0);

  ////////////////////////////////////////////////////////////////////////
  // Power state tracking
  // State codes of the power machine
  localparam PS_NORMAL = `DDRC_PS_NORMAL;
  localparam PS_PPD    = `DDRC_PS_PPD;
  localparam PS_APD    = `DDRC_PS_APD;
  localparam PS_SREF   = `DDRC_PS_SREF;

  reg [1:0] nxt_pwr;
  always @* begin
    nxt_pwr = pwr_state_ff;
    if (rise) begin
      case (pwr_state_ff)
        PS_NORMAL: begin
          // Clock enable falling: refresh enters self refresh, idle bus powers down
          if (cke_prev_ff && !s_cke) begin
            if (kind == `DDRC_K_SREF) begin
              nxt_pwr = PS_SREF;
            end else if (kind == `DDRC_K_NONE) begin
              nxt_pwr = idle ? PS_PPD : PS_APD;
            end
          end
        end
        PS_PPD, PS_APD, PS_SREF: begin
          // Leave only on clock enable high with a no-operation
          if (s_cke && kind == `DDRC_K_NONE) begin
            nxt_pwr = PS_NORMAL;
          end
        end
        default: nxt_pwr = PS_NORMAL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command effects
  wire [3:0] bank_bit = 4'h1 << s_ba;
  wire       wr_ap    = (kind == `DDRC_K_READ || kind == `DDRC_K_WRITE) & s_ap;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_kind_ff    <= `DDRC_K_NONE;
      cmd_stb_ff     <= 1'b0;
      cmd_bank_ff    <= 2'h0;
      cmd_addr_ff    <= {ROW_W{1'b0}};
      cmd_ap_ff      <= 1'b0;
      bank_open_ff   <= 4'h0;
      pwr_state_ff   <= `DDRC_PS_NORMAL;
      mode_reg_ff    <= {ROW_W{1'b0}};
      emode_reg_ff   <= {ROW_W{1'b0}};
      mode_valid_ff  <= 1'b0;
      emode_valid_ff <= 1'b0;
      dll_reset_ff   <= 1'b0;
      burst_len_ff   <= 3'h0;
      burst_type_ff  <= 1'b0;
      cas_lat_ff     <= 3'h0;
      ref_bank_ff    <= 2'h0;
      ref_row_ff     <= {ROW_W{1'b0}};
      rd_active_ff   <= 1'b0;
    end else begin
      pwr_state_ff <= nxt_pwr;
      cmd_stb_ff   <= exec & (kind != `DDRC_K_NONE);
      if (exec && kind != `DDRC_K_NONE) begin
        cmd_kind_ff <= kind;
        cmd_bank_ff <= s_ba;
        cmd_addr_ff <= s_addr;
        cmd_ap_ff   <= wr_ap;
      end
      if (exec) begin
        case (kind)
          `DDRC_K_ACT:    bank_open_ff <= bank_open_ff | bank_bit;
          `DDRC_K_READ: begin
            rd_active_ff <= ~s_ap;
            if (s_ap) begin
              bank_open_ff <= bank_open_ff & ~bank_bit;
            end
          end
          `DDRC_K_WRITE: begin
            rd_active_ff <= 1'b0;
            if (s_ap) begin
              bank_open_ff <= bank_open_ff & ~bank_bit;
            end
          end
          `DDRC_K_BST:    rd_active_ff <= 1'b0;
          `DDRC_K_PRE:    bank_open_ff <= bank_open_ff & ~bank_bit;
          `DDRC_K_PREALL: bank_open_ff <= 4'h0;
          `DDRC_K_AREF, `DDRC_K_SREF: begin
            // Internal counters pick bank and row; pins ignored
            {ref_row_ff, ref_bank_ff} <= {ref_row_ff, ref_bank_ff} + 1'b1;
          end
          `DDRC_K_MRS: begin
            mode_reg_ff   <= s_addr;
            mode_valid_ff <= 1'b1;
            burst_len_ff  <= s_addr[`DDRC_MR_BL_LSB +: 3];
            burst_type_ff <= s_addr[`DDRC_MR_BT_BIT];
            cas_lat_ff    <= s_addr[`DDRC_MR_CL_LSB +: 3];
            dll_reset_ff  <= s_addr[`DDRC_MR_DLL_BIT];
          end
          `DDRC_K_EMRS: begin
            emode_reg_ff   <= s_addr;
            emode_valid_ff <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write data pairing: two half-clock elements form one core word
  reg [DQ_W-1:0] lo_ff;
  reg            lo_dm_ff;
  reg            wr_on_ff;
  reg            lo_vld_ff;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      lo_ff          <= {DQ_W{1'b0}};
      lo_dm_ff       <= 1'b0;
      wr_on_ff       <= 1'b0;
      lo_vld_ff      <= 1'b0;
      wr_word_ff     <= {2*DQ_W{1'b0}};
      wr_mask_ff     <= 2'h0;
      wr_word_stb_ff <= 1'b0;
    end else begin
      wr_word_stb_ff <= 1'b0;
      // A real command other than a write ends the write window, a write restarts it; no-operation keeps it open
      if (exec && kind != `DDRC_K_NONE) begin
        wr_on_ff  <= (kind == `DDRC_K_WRITE);
        lo_vld_ff <= 1'b0;
      end else if (rise && wr_on_ff) begin
        lo_ff     <= s_dq;
        lo_dm_ff  <= s_dm;
        lo_vld_ff <= 1'b1;
      end
      // Pair only a rising element captured inside this write window
      if (fall && wr_on_ff && lo_vld_ff) begin
        wr_word_ff     <= {s_dq, lo_ff};
        wr_mask_ff     <= {s_dm, lo_dm_ff};
        wr_word_stb_ff <= 1'b1;
        lo_vld_ff      <= 1'b0;
      end
    end
  end

endmodule

/* dv/ddrc_cmd_monitor.sv */
// Checker on the command decode block outputs
`timescale 1ns/1ps
`include "ddrc_defs.vh"
module ddrc_cmd_monitor #(parameter ROW_W = 13) (
  input wire             mclk,
  input wire             rst,
  input wire [3:0]       cmd_kind_ff,
  input wire             cmd_stb_ff,
  input wire [1:0]       cmd_bank_ff,
  input wire [ROW_W-1:0] cmd_addr_ff,
  input wire [3:0]       bank_open_ff,
  input wire [1:0]       pwr_state_ff,
  input wire [ROW_W-1:0] emode_reg_ff,
  input wire             rd_active_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_stb_pulse: assert property (cmd_stb_ff |=> !cmd_stb_ff [*3])
    else $error("strobe too long");
  chk_kind_hold: assert property (!cmd_stb_ff |-> $stable(cmd_kind_ff))
    else $error("kind moved without strobe");
  chk_act_open: assert property (cmd_stb_ff && cmd_kind_ff == `DDRC_K_ACT
    |-> bank_open_ff[cmd_bank_ff]) else $error("row not opened");
  chk_bst_stop: assert property (cmd_stb_ff && cmd_kind_ff == `DDRC_K_BST
    |-> !rd_active_ff) else $error("read still active");
  chk_preall_shut: assert property (cmd_stb_ff && cmd_kind_ff == `DDRC_K_PREALL
    |-> bank_open_ff == 4'h0) else $error("bank left open");
  chk_sref_enter: assert property (cmd_stb_ff && cmd_kind_ff == `DDRC_K_SREF
    |-> pwr_state_ff == `DDRC_PS_SREF) else $error("no self refresh");
  chk_emrs_load: assert property (cmd_stb_ff && cmd_kind_ff == `DDRC_K_EMRS
    |-> emode_reg_ff == cmd_addr_ff) else $error("extended mode not loaded");
  chk_pd_quiet: assert property (pwr_state_ff != 2'h0 && $past(pwr_state_ff) != 2'h0
    |-> !cmd_stb_ff) else $error("command while powered down");
  cover property (cmd_stb_ff && cmd_kind_ff == `DDRC_K_WRITE);
  cover property (pwr_state_ff == `DDRC_PS_APD);
  cover property (pwr_state_ff == `DDRC_PS_PPD);
endmodule

/* dv/ddrc_ctl_model.sv */
// Behavioural memory controller driving the command pins
`timescale 1ns/1ps
module ddrc_ctl_model (
  output logic        ck_p,
  output logic        ck_n,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [1:0]  ba,
  output logic [12:0] addr,
  output logic [15:0] dq_in,
  output logic        dm
);
  // Free running memory clock, pins idle with clock enable low
  initial begin
    {cke, ba, addr, dq_in, dm} = '0;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ck_p = 1'b0;
    forever #40 ck_p = ~ck_p;
  end
  assign ck_n = ~ck_p;
  // One command for one memory clock, then the bus idles
  task automatic issue(input logic e, c, input logic [2:0] r, input logic [1:0] b,
                       input logic [12:0] a);
    @(negedge ck_p) #1;
    {cke, cs_n, ras_n, cas_n, we_n, ba, addr} = {e, c, r, b, a};
    @(negedge ck_p) #1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {ba, addr} = ~{b, a};
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ck_p);
  endtask
endmodule

/* dv/ddr_sdram_command_init_test.sv */
// Bench for command decode, power states and mode loading
`timescale 1ns/1ps
`include "ddrc_defs.vh"
module ddr_sdram_command_init_test;
  localparam int PWRUP = 2500; // 200 us of 80 ns memory clocks
  logic        mclk, rst;
  int          num_errors, checked, nstb, nwr, cyc;
  wire         ck_p, ck_n, cke, cs_n, ras_n, cas_n, we_n, dm, stb, ap, rda, dll;
  wire         mv, emv, bt, wst;
  wire [1:0]   ba, pwr, mask, rb;
  wire [2:0]   bl, cl;
  wire [3:0]   kind, bopen;
  wire [12:0]  addr, mreg, rr;
  wire [15:0]  dq;
  wire [31:0]  word;
  ddrc_ctl_model u_ctl (.ck_p(ck_p), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq), .dm(dm));
  ddrc_cmd DUT (.mclk(mclk), .rst(rst), .ck_p(ck_p), .ck_n(ck_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq), .dm(dm),
    .cmd_kind_ff(kind), .cmd_stb_ff(stb), .cmd_bank_ff(), .cmd_addr_ff(), .cmd_ap_ff(ap),
    .bank_open_ff(bopen), .pwr_state_ff(pwr), .mode_reg_ff(mreg), .emode_reg_ff(),
    .mode_valid_ff(mv), .emode_valid_ff(emv), .dll_reset_ff(dll), .burst_len_ff(bl),
    .burst_type_ff(bt), .cas_lat_ff(cl), .ref_bank_ff(rb), .ref_row_ff(rr),
    .rd_active_ff(rda), .wr_word_ff(word), .wr_mask_ff(mask), .wr_word_stb_ff(wst));
  // System clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Strobe counter and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (stb === 1'b1) nstb <= nstb + 1;
    if (wst === 1'b1) nwr <= nwr + 1;
    if (cyc == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Issue one command and judge strobe count and decoded kind
  task automatic op(input logic e, c, input logic [2:0] r, input logic [1:0] b,
                    input logic [12:0] a, input logic [3:0] k);
    int n0 = nstb;
    u_ctl.issue(e, c, r, b, a);
    repeat (6) @(posedge mclk);
    chk("stb", nstb - n0, k != `DDRC_K_NONE);
    if (k != `DDRC_K_NONE) chk("kind", kind, k);
  endtask
  task automatic test_init();
    op(1, 0, `DDRC_CMD_NOP, 2'h0, 13'h0, `DDRC_K_NONE);
    u_ctl.idle(PWRUP);
    op(1, 0, `DDRC_CMD_PRE, 2'h2, 13'h400, `DDRC_K_PREALL);
    u_ctl.idle(2);
    op(1, 0, `DDRC_CMD_MRS, `DDRC_BA_EMODE, 13'h0, `DDRC_K_EMRS);
    chk("emv", {mv, emv}, 2'h1);
    op(1, 0, `DDRC_CMD_MRS, `DDRC_BA_MODE, 13'h132, `DDRC_K_MRS);
    chk("mode", {dll, cl, bl}, 32'h5a);
    chk("mv", mv, 1'b1);
    u_ctl.idle(200);
    op(1, 0, `DDRC_CMD_REF, 2'h1, 13'h0, `DDRC_K_AREF);
    op(1, 0, `DDRC_CMD_PRE, 2'h0, 13'h400, `DDRC_K_PREALL);
    repeat (2) op(1, 0, `DDRC_CMD_REF, 2'h3, 13'h1fff, `DDRC_K_AREF);
    chk("refc", {rr, rb}, 15'h3);
    op(1, 0, `DDRC_CMD_MRS, `DDRC_BA_MODE, 13'h03a, `DDRC_K_MRS);
    chk("mode", {dll, cl, bl}, 32'h1a);
    chk("mreg", {bt, mreg}, 14'h203a);
    op(1, 0, `DDRC_CMD_MRS, 2'h2, 13'h1fff, `DDRC_K_NONE);
    chk("mreg", mreg, 13'h03a);
    $display("init done");
  endtask
  task automatic test_access();
    op(1, 1, `DDRC_CMD_ACT, 2'h2, 13'h123, `DDRC_K_NONE);
    op(1, 0, `DDRC_CMD_ACT, 2'h2, 13'h1abc, `DDRC_K_ACT);
    chk("open", bopen, 4'h4);
    op(1, 0, `DDRC_CMD_READ, 2'h2, 13'h400, `DDRC_K_READ);
    chk("ap", {ap, bopen}, 5'h10);
    op(1, 0, `DDRC_CMD_ACT, 2'h2, 13'h1abc, `DDRC_K_ACT);
    op(1, 0, `DDRC_CMD_READ, 2'h2, 13'h0, `DDRC_K_READ);
    chk("rd", {ap, rda}, 2'h1);
    op(1, 0, `DDRC_CMD_BST, 2'h0, 13'h0, `DDRC_K_BST);
    op(1, 0, `DDRC_CMD_PRE, 2'h2, 13'h0, `DDRC_K_PRE);
    chk("open", {rda, bopen}, 5'h0);
    $display("access done");
  endtask
  task automatic test_write();
    int n0;
    op(1, 0, `DDRC_CMD_ACT, 2'h1, 13'h55, `DDRC_K_ACT);
    u_ctl.dq_in = 16'ha55a;
    n0 = nwr;
    op(1, 0, `DDRC_CMD_WRITE, 2'h1, 13'h5, `DDRC_K_WRITE);
    // Rising element of the first data clock is a55a, its falling element 3cc3
    #1 u_ctl.dq_in = 16'h3cc3;
    u_ctl.idle(1);
    chk("word", word, 32'h3cc3a55a);
    chk("mask", mask, 2'h0);
    chk("nwr", nwr - n0, 32'h1);
    u_ctl.dm = 1'b1;
    u_ctl.idle(2);
    chk("mask", mask, 2'h3);
    u_ctl.dm = 1'b0;
    op(1, 0, `DDRC_CMD_WRITE, 2'h1, 13'h400, `DDRC_K_WRITE);
    chk("wap", {ap, bopen}, 5'h10);
    $display("write done");
  endtask
  task automatic test_power();
    op(1, 0, `DDRC_CMD_ACT, 2'h0, 13'h7, `DDRC_K_ACT);
    op(0, 0, `DDRC_CMD_NOP, 2'h0, 13'h0, `DDRC_K_NONE);
    chk("apd", pwr, `DDRC_PS_APD);
    op(0, 0, `DDRC_CMD_ACT, 2'h1, 13'h7, `DDRC_K_NONE);
    chk("hold", {pwr, bopen}, 6'h21);
    op(1, 0, `DDRC_CMD_NOP, 2'h0, 13'h0, `DDRC_K_NONE);
    op(1, 0, `DDRC_CMD_PRE, 2'h0, 13'h400, `DDRC_K_PREALL);
    op(0, 1, `DDRC_CMD_NOP, 2'h0, 13'h0, `DDRC_K_NONE);
    chk("ppd", pwr, `DDRC_PS_PPD);
    op(1, 1, `DDRC_CMD_NOP, 2'h0, 13'h0, `DDRC_K_NONE);
    op(0, 0, `DDRC_CMD_REF, 2'h0, 13'h0, `DDRC_K_SREF);
    chk("refc", {rr, rb}, 15'h4);
    op(1, 0, `DDRC_CMD_NOP, 2'h0, 13'h0, `DDRC_K_NONE);
    chk("exit", pwr, `DDRC_PS_NORMAL);
    u_ctl.idle(10);
    $display("power done");
  endtask
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    chk("rst", {kind, pwr, bopen, mv, emv, rr, rb}, 32'h0);
    test_init();
    test_access();
    test_write();
    test_power();
    tally_and_finish();
  end
endmodule
bind ddrc_cmd ddrc_cmd_monitor #(.ROW_W(ROW_W)) u_mon (.mclk(mclk), .rst(rst),
  .cmd_kind_ff(cmd_kind_ff), .cmd_stb_ff(cmd_stb_ff), .cmd_bank_ff(cmd_bank_ff),
  .cmd_addr_ff(cmd_addr_ff), .bank_open_ff(bank_open_ff), .pwr_state_ff(pwr_state_ff),
  .emode_reg_ff(emode_reg_ff), .rd_active_ff(rd_active_ff));
